// ### hw/hft_top.sv
// Four channel high flux trip block with two-out-of-four plant trip voting.
// Assumes flux inputs and the keyswitch are synchronous to pclk; registers sit on APB.
//
// Behaviour
// - every channel sees all four channel fluxes
// - select second-largest of four channel totals
// - total equals chamber sum times gain
// - gain adjustable 0.5 to 1.5, default 1.000
// - trip when selected flux reaches setpoint
// - normal setpoint is 104.75 percent
// - bypass keyswitch selects 4.0 percent automatically
// - enabled variable setpoint 0 to 125 percent
// - normal setpoint stays active with variable
// - two of four channels trip the plant
// - plant trip latched until operator reset
// - chamber inputs span 0 to 62.5 percent
// - external summed power signal never used
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module hft_top (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave port.
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Detector chamber values, one pair per channel.
  input  wire hft_pkg::hft_flux_pair_t [3:0] flux_detector_input,
  // Shutdown bypass keyswitch, high in bypass.
  input  wire logic                          bypass_key,
  // Operator reset of the latched plant trip.
  input  wire logic                          operator_reset,
  output logic [3:0]                         channel_trip,
  output logic                               plant_trip,
  output logic                               irq
);

  // Control registers written by software.
  logic        var_en;                 // Variable setpoint enable.
  logic [10:0] gain;                   // Total flux gain factor.
  logic [15:0] var_sp;                 // Variable setpoint value.
  logic [15:0] hyst;                   // Auto-reset margin.
  logic [1:0]  irq_stat;               // Sticky event bits.
  logic [1:0]  irq_mask;               // Interrupt enables.
  logic        next_var_en;
  logic [10:0] next_gain;
  logic [15:0] next_var_sp;
  logic [15:0] next_hyst;
  logic [1:0]  next_irq_stat;
  logic [1:0]  next_irq_mask;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  // Datapath signals.
  logic [4*16-1:0]      totals;        // Registered channel totals.
  logic [4*16-1:0]      next_totals;
  hft_pkg::hft_sp_cfg_t cfg;           // Configuration fed to every channel.
  logic [15:0]          sel_flux [4];  // Runner-up value seen by each channel.
  logic [3:0]           chan_trip_q;   // Channel trips from the comparators.
  logic [3:0]           chan_trip_d;   // Channel trips one cycle earlier.
  hft_pkg::hft_latch_t  latch;
  hft_pkg::hft_latch_t  next_latch;
  logic [2:0]           votes;         // Number of tripped channels.
  logic                 vote_trip;
  logic [1:0]           events;        // Event pulses toward the sticky bits.

  // Bus decode terms.
  logic wr_access;
  logic rd_setup;

  // The slave answers with no wait state; read data are captured in setup.
  assign pready    = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign rd_setup  = psel && !penable;

  // Compute each channel's total from its own two chamber values.
  always_comb
  begin
    next_totals = '0;
    for (int c = 0; c < hft_pkg::NCHAN; c++)
    begin : totals_loop
      logic [15:0] up;
      logic [15:0] lo;
      logic [16:0] sum;
      logic [27:0] prod;
      // Every local gets a value first so no stale state is implied.
      sum  = 17'h00000;
      prod = 28'h0000000;
      up   = flux_detector_input[c].upper;
      lo   = flux_detector_input[c].lower;
      if (up > hft_pkg::CHAMBER_MAX)
      begin
        up = hft_pkg::CHAMBER_MAX;
      end
      if (lo > hft_pkg::CHAMBER_MAX)
      begin
        lo = hft_pkg::CHAMBER_MAX;
      end
      sum  = {1'b0, up} + {1'b0, lo};
      prod = 28'(sum * gain);
      // With gain at most 1.5 the scaled total stays below 2**15.
      next_totals[c*16 +: 16] = prod[hft_pkg::GAIN_FRAC +: 16];
    end
  end

  // Totals register: one processing cycle of latency for every channel.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      totals <= '0;
    end
    else
    begin
      totals <= next_totals;
    end
  end

  // Configuration bundle for the comparators.
  always_comb
  begin
    cfg.bypass = bypass_key;
    cfg.var_en = var_en;
    cfg.var_sp = var_sp;
    cfg.hyst   = hyst;
  end

  // Four identical channels, each fed all four totals.
  genvar gc;
  generate
    for (gc = 0; gc < hft_pkg::NCHAN; gc++)
    begin : g_chan
      hft_chan u_chan (
        .pclk                      (pclk),
        .presetn                   (presetn),
        .totals                    (totals),
        .cfg                       (cfg),
        .trip                      (chan_trip_q[gc]),
        .second_highest_total_flux (sel_flux[gc])
      );
    end
  endgenerate

  // Count the tripped channels for voting.
  always_comb
  begin
    votes = 3'h0;
    for (int v = 0; v < hft_pkg::NCHAN; v++)
    begin
      votes = votes + {2'h0, chan_trip_q[v]};
    end
    vote_trip = (votes >= 3'h2);
  end

  // Plant trip latch: only the operator reset or presetn can clear it, and a standing vote
  // wins over the reset so the plant cannot be cleared while still tripped.
  always_comb
  begin
    next_latch = latch;
    case (latch)
      hft_pkg::HFT_LATCH_CLEAR:
      begin
        if (vote_trip)
        begin
          next_latch = hft_pkg::HFT_LATCH_TRIPPED;
        end
      end
      hft_pkg::HFT_LATCH_TRIPPED:
      begin
        if (operator_reset && !vote_trip)
        begin
          next_latch = hft_pkg::HFT_LATCH_CLEAR;
        end
      end
      default:
      begin
        next_latch = hft_pkg::HFT_LATCH_TRIPPED;
      end
    endcase
  end

  // Latch and edge-detect registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch       <= hft_pkg::HFT_LATCH_CLEAR;
      chan_trip_d <= 4'h0;
    end
    else
    begin
      latch       <= next_latch;
      chan_trip_d <= chan_trip_q;
    end
  end

  // Outputs come straight from flops.
  assign channel_trip = chan_trip_q;
  assign plant_trip   = (latch == hft_pkg::HFT_LATCH_TRIPPED);

  // Events: plant trip entry and any channel newly tripping.
  always_comb
  begin
    events                    = 2'h0;
    events[hft_pkg::IRQ_PLANT] = (latch == hft_pkg::HFT_LATCH_CLEAR) &&
                                 (next_latch == hft_pkg::HFT_LATCH_TRIPPED);
    events[hft_pkg::IRQ_CHAN]  = |(chan_trip_q & ~chan_trip_d);
  end

  // Register writes. Values outside their permitted range are ignored, so a
  // console slip can never push the gain or variable setpoint out of range.
  always_comb
  begin
    next_var_en   = var_en;
    next_gain     = gain;
    next_var_sp   = var_sp;
    next_hyst     = hyst;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr_access)
    begin
      case (paddr)
        hft_pkg::OFS_CTRL:
        begin
          next_var_en = pwdata[hft_pkg::CTRL_VAR_EN];
        end
        hft_pkg::OFS_GAIN:
        begin
          if ((pwdata[31:11] == 21'h0) && (pwdata[10:0] >= hft_pkg::GAIN_MIN) &&
              (pwdata[10:0] <= hft_pkg::GAIN_MAX))
          begin
            next_gain = pwdata[10:0];
          end
        end
        hft_pkg::OFS_VAR_SP:
        begin
          if ((pwdata[31:16] == 16'h0000) && (pwdata[15:0] <= hft_pkg::VAR_SP_MAX))
          begin
            next_var_sp = pwdata[15:0];
          end
        end
        hft_pkg::OFS_HYST:
        begin
          next_hyst = pwdata[15:0];
        end
        hft_pkg::OFS_IRQ_STAT:
        begin
          // Write one to clear.
          next_irq_stat = irq_stat & ~pwdata[hft_pkg::IRQ_W-1:0];
        end
        hft_pkg::OFS_IRQ_MASK:
        begin
          next_irq_mask = pwdata[hft_pkg::IRQ_W-1:0];
        end
        default:
        begin
          next_irq_stat = irq_stat;
        end
      endcase
    end
    // A new event wins over a clear in the same cycle.
    next_irq_stat = next_irq_stat | events;
  end

  // Read data and error are prepared in the setup cycle and held for access.
  always_comb
  begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (rd_setup)
    begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      case (paddr)
        hft_pkg::OFS_CTRL:     next_prdata[hft_pkg::CTRL_VAR_EN] = var_en;
        hft_pkg::OFS_GAIN:     next_prdata[10:0] = gain;
        hft_pkg::OFS_VAR_SP:   next_prdata[15:0] = var_sp;
        hft_pkg::OFS_HYST:     next_prdata[15:0] = hyst;
        hft_pkg::OFS_STATUS:
        begin
          next_prdata[3:0]                  = chan_trip_q;
          next_prdata[hft_pkg::STAT_PLANT]  = plant_trip;
          next_prdata[hft_pkg::STAT_BYPASS] = bypass_key;
          next_prdata[hft_pkg::STAT_VAR_EN] = var_en;
        end
        hft_pkg::OFS_IRQ_STAT: next_prdata[hft_pkg::IRQ_W-1:0] = irq_stat;
        hft_pkg::OFS_IRQ_MASK: next_prdata[hft_pkg::IRQ_W-1:0] = irq_mask;
        hft_pkg::OFS_SEL_FLUX: next_prdata[15:0] = sel_flux[0];
        default:               next_pslverr = 1'b1;
      endcase
    end
  end

  // Software register file.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      var_en   <= 1'b0;
      gain     <= hft_pkg::GAIN_ONE;
      var_sp   <= hft_pkg::VAR_SP_RST;
      hyst     <= hft_pkg::HYST_RST;
      irq_stat <= 2'h0;
      irq_mask <= hft_pkg::IRQ_MASK_RST;
      prdata   <= 32'h0000_0000;
      pslverr  <= 1'b0;
    end
    else
    begin
      var_en   <= next_var_en;
      gain     <= next_gain;
      var_sp   <= next_var_sp;
      hyst     <= next_hyst;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      prdata   <= next_prdata;
      pslverr  <= next_pslverr;
    end
  end

  // Level interrupt while any unmasked sticky bit stands.
  assign irq = |(irq_stat & irq_mask);

endmodule : hft_top

// ### hw/hft_pkg.sv
// Package for the high flux trip channel block: constants, register map and carrier types.
// Assumes flux values in hundredths of a percent of rated power and a 100 MHz pclk.
package hft_pkg;

  // Flux words are unsigned, in units of 0.01 percent of rated power.
  localparam int          FLUX_W       = 16;
  localparam int          NCHAN        = 4;
  // Each chamber spans 0 to 62.5 percent, so a chamber sum spans 0 to 125 percent before gain.
  localparam logic [15:0] CHAMBER_MAX  = 16'h186A;
  localparam logic [15:0] TOTAL_MAX    = 16'h30D4;
  // Normal setpoint 104.75 percent and shutdown bypass setpoint 4.0 percent.
  localparam logic [15:0] NORMAL_SP    = 16'h28EB;
  localparam logic [15:0] BYPASS_SP    = 16'h0190;
  // Variable setpoint range 0 to 125 percent, reset value 104.75 percent.
  localparam logic [15:0] VAR_SP_MAX   = 16'h30D4;
  localparam logic [15:0] VAR_SP_RST   = 16'h28EB;
  // Auto-reset margin below the active setpoint, 0.5 percent after reset.
  localparam logic [15:0] HYST_RST     = 16'h0032;

  // Gain is unsigned fixed point with ten fraction bits: 1.000, 0.5 and 1.5.
  localparam int          GAIN_W       = 11;
  localparam int          GAIN_FRAC    = 10;
  localparam logic [10:0] GAIN_ONE     = 11'h400;
  localparam logic [10:0] GAIN_MIN     = 11'h200;
  localparam logic [10:0] GAIN_MAX     = 11'h600;

  // Register byte offsets on the APB bus.
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_GAIN     = 8'h04;
  localparam logic [7:0]  OFS_VAR_SP   = 8'h08;
  localparam logic [7:0]  OFS_HYST     = 8'h0C;
  localparam logic [7:0]  OFS_STATUS   = 8'h10;
  localparam logic [7:0]  OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0]  OFS_SEL_FLUX = 8'h1C;

  // Field positions.
  localparam int          CTRL_VAR_EN  = 0;
  localparam int          STAT_PLANT   = 4;
  localparam int          STAT_BYPASS  = 5;
  localparam int          STAT_VAR_EN  = 6;
  localparam int          IRQ_PLANT    = 0;
  localparam int          IRQ_CHAN     = 1;
  localparam int          IRQ_W        = 2;
  localparam logic [1:0]  IRQ_MASK_RST = 2'h0;

  // Upper and lower chamber values of one channel travel together.
  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
  } hft_flux_pair_t;

  // Setpoint configuration shared by every channel comparator.
  typedef struct packed {
    logic        bypass;
    logic        var_en;
    logic [15:0] var_sp;
    logic [15:0] hyst;
  } hft_sp_cfg_t;

  // Plant trip latch state.
  typedef enum logic [0:0] {
    HFT_LATCH_CLEAR   = 1'b0,
    HFT_LATCH_TRIPPED = 1'b1
  } hft_latch_t;

endpackage : hft_pkg

// ### hw/hft_chan.sv
// One trip channel: ranks the four channel totals and compares the runner-up value.
// Assumes totals arrive registered from the top and the configuration is stable per cycle.
`timescale 1ns/1ps
module hft_chan (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [4*16-1:0]     totals,
  input  wire hft_pkg::hft_sp_cfg_t cfg,
  output logic                     trip,
  output logic [15:0]              second_highest_total_flux
);

  // Rank of each total: how many others beat it, with ties broken by index.
  logic [2:0]  rank [4];
  logic [15:0] tot  [4];
  logic [15:0] pick;
  logic [15:0] active_sp;
  logic [15:0] reset_level;
  logic        next_trip;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_rank
      assign tot[gi] = totals[gi*16 +: 16];
      always_comb
      begin
        rank[gi] = 3'h0;
        for (int j = 0; j < 4; j++)
        begin
          if ((tot[j] > tot[gi]) || ((tot[j] == tot[gi]) && (j < gi)))
          begin
            rank[gi] = rank[gi] + 3'h1;
          end
        end
      end
    end
  endgenerate

  // Exactly one entry holds rank one; it is the second-largest total.
  always_comb
  begin
    pick = 16'h0000;
    for (int k = 0; k < 4; k++)
    begin
      if (rank[k] == 3'h1)
      begin
        pick = tot[k];
      end
    end
  end

  // Setpoint choice: bypass replaces normal, variable only ever lowers it.
  always_comb
  begin
    active_sp = cfg.bypass ? hft_pkg::BYPASS_SP : hft_pkg::NORMAL_SP;
    if (cfg.var_en && (cfg.var_sp < active_sp))
    begin
      active_sp = cfg.var_sp;
    end
    // The margin saturates at zero so a large margin never wraps round.
    reset_level = (cfg.hyst > active_sp) ? 16'h0000 : (active_sp - cfg.hyst);
  end

  // Trip comparator with self-clearing below the auto-reset level.
  always_comb
  begin
    next_trip = trip;
    if (pick >= active_sp)
    begin
      next_trip = 1'b1;
    end
    else if (pick < reset_level)
    begin
      next_trip = 1'b0;
    end
  end

  // Registers of the channel.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trip                      <= 1'b0;
      second_highest_total_flux <= 16'h0000;
    end
    else
    begin
      trip                      <= next_trip;
      second_highest_total_flux <= pick;
    end
  end

endmodule : hft_chan

// ### tb/hft_props.sv
// Checker for the high flux trip block: vote, latch, channel agreement and bus answers.
// Assumes it is bound to hft_top and sees only that module's ports.
`timescale 1ns/1ps
module hft_props (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic [7:0]                    paddr,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire hft_pkg::hft_flux_pair_t [3:0] flux_detector_input,
  input wire logic                          bypass_key,
  input wire logic                          operator_reset,
  input wire logic [3:0]                    channel_trip,
  input wire logic                          plant_trip
);
  // High while two or more channels are tripped.
  logic two_up;
  // High while every chamber reads at least 4.0 percent, enough even at the lowest gain.
  logic all_hi;
  assign two_up = $countones(channel_trip) >= 2;

  // Every chamber is compared, so one low reading keeps the bypass check quiet.
  always_comb
  begin
    all_hi = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (flux_detector_input[i].upper < 16'h0190 || flux_detector_input[i].lower < 16'h0190)
      begin
        all_hi = 1'b0;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_plant_vote: assert property (two_up |=> plant_trip)
    else $error("plant trip missing after two channel trips");
  a_plant_cause: assert property ($rose(plant_trip) |-> $past(two_up))
    else $error("plant trip rose without two channel trips");
  a_plant_latch: assert property (plant_trip && !operator_reset |=> plant_trip)
    else $error("plant trip cleared without operator reset");
  a_only_reset_clears: assert property ($fell(plant_trip) |-> $past(operator_reset))
    else $error("plant trip fell with no operator reset before it");
  a_chan_agree: assert property (channel_trip == 4'h0 || channel_trip == 4'hF)
    else $error("channels disagree on the same four totals");
  a_bypass_trip: assert property ((bypass_key && all_hi) [*3] |-> channel_trip == 4'hF)
    else $error("bypass setpoint did not trip the channels");
  a_unmapped_err: assert property (psel && !penable && paddr > 8'h1C |=> pslverr)
    else $error("unmapped access gave no slave error");
  a_mapped_ok: assert property (psel && !penable && paddr <= 8'h1C && paddr[1:0] == 2'h0
                                |=> !pslverr)
    else $error("mapped access gave a slave error");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
endmodule : hft_props

bind hft_top hft_props i_hft_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .flux_detector_input(flux_detector_input),
  .bypass_key(bypass_key), .operator_reset(operator_reset),
  .channel_trip(channel_trip), .plant_trip(plant_trip)
);

// ### tb/hft_det_model.sv
// Detector amplifier model: turns a requested channel total into upper and lower chambers.
// Assumes requested totals stay within 0 to 125 percent in hundredths.
`timescale 1ns/1ps
module hft_det_model (
  input  wire logic [63:0]              total_req,
  output hft_pkg::hft_flux_pair_t [3:0] flux
);
  // The total is split in halves; the odd hundredth goes to the lower chamber.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      flux[i].upper = total_req[16*i +: 16] >> 1;
      flux[i].lower = total_req[16*i +: 16] - (total_req[16*i +: 16] >> 1);
    end
  end
endmodule : hft_det_model

// ### tb/tb_top.sv
// Self-checking bench for the four channel high flux trip block.
// Assumes the detector model drives the chambers and this bench acts as console and APB master.
`timescale 1ns/1ps
module tb_top;
  // One table row: four totals, keyswitch, expected trips and selected flux.
  typedef struct packed {
    logic [63:0] tot;
    logic        byp;
    logic [3:0]  trip;
    logic [15:0] sel;
  } hft_row_t;
  logic                          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]                    paddr;
  logic [31:0]                   pwdata, prdata, rd;
  hft_pkg::hft_flux_pair_t [3:0] flux;
  logic                          bypass_key, operator_reset, plant_trip, irq, err;
  logic [3:0]                    channel_trip;
  logic [63:0]                   total_req;
  int                            num_errors, checks_done, cycles;
  // Order matters: hysteresis carries each row's trip state into the next.
  hft_row_t rows [12] = '{
    '{64'h01F4_07D0_0BB8_03E8, 1'b0, 4'h0, 16'h07D0},
    '{64'h0000_0000_28EA_28EA, 1'b0, 4'h0, 16'h28EA},
    '{64'h0000_0000_28EB_28EB, 1'b0, 4'hF, 16'h28EB},
    '{64'h0000_0000_30D4_28EA, 1'b0, 4'hF, 16'h28EA},
    '{64'h0000_0000_30D4_28B8, 1'b0, 4'h0, 16'h28B8},
    '{64'h0320_0320_0320_0320, 1'b1, 4'hF, 16'h0320},
    '{64'h0000_0000_018F_018F, 1'b1, 4'hF, 16'h018F},
    '{64'h0000_0000_015D_015D, 1'b1, 4'h0, 16'h015D},
    '{64'h0000_0000_0190_0190, 1'b1, 4'hF, 16'h0190},
    '{64'h0000_0000_0000_0000, 1'b0, 4'h0, 16'h0000},
    '{64'h30D4_30D4_30D4_30D4, 1'b0, 4'hF, 16'h30D4},
    '{64'h0001_0001_0005_0005, 1'b0, 4'h0, 16'h0005}};
  // Registers and their values straight after reset.
  logic [7:0]  rst_ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18};
  logic [31:0] rst_val [6] = '{32'h0, 32'h400, 32'h28EB, 32'h32, 32'h0, 32'h0};

  hft_top i_hft_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flux_detector_input(flux), .bypass_key(bypass_key), .operator_reset(operator_reset),
    .channel_trip(channel_trip), .plant_trip(plant_trip), .irq(irq));
  hft_det_model i_hft_det_model (.total_req(total_req), .flux(flux));

  // Free-running 100 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Cuts a hang short; the whole run needs a few hundred cycles.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : chk

  // One APB transfer; waits for ready rather than assuming the wait count.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reads one register and compares it.
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rd_chk

  // Applies totals and keyswitch, then lets the fixed three-edge pipeline settle.
  task automatic drive(input logic [63:0] t, input logic b);
    @(posedge pclk);
    total_req <= t;
    bypass_key <= b;
    repeat (4) @(posedge pclk);
  endtask : drive

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, bypass_key, operator_reset} = '0;
    total_req = '0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      drive(rows[i].tot, rows[i].byp);
      chk("channel_trip", 32'(rows[i].trip), 32'(channel_trip));
      rd_chk("sel_flux", hft_pkg::OFS_SEL_FLUX, 32'(rows[i].sel));
    end
    // The latch holds with no trips left, and the vote beats an operator reset.
    chk("plant_hold", 32'h1, 32'(plant_trip));
    operator_reset <= 1'b1;
    drive(64'h0000_0000_28EB_28EB, 1'b0);
    chk("plant_vote", 32'h1, 32'(plant_trip));
    // A reset that beat the vote would drop the latch one edge later.
    @(posedge pclk);
    chk("plant_vote_hold", 32'h1, 32'(plant_trip));
    drive(64'h0, 1'b0);
    chk("plant_clear", 32'h0, 32'(plant_trip));
    operator_reset <= 1'b0;
    // Sticky events, mask and write-one-to-clear.
    apb(1'b1, hft_pkg::OFS_IRQ_MASK, 32'h3);
    // The mask lands at the access edge, so irq is looked at one edge later.
    @(posedge pclk);
    chk("irq_on", 32'h1, 32'(irq));
    rd_chk("irq_stat", hft_pkg::OFS_IRQ_STAT, 32'h3);
    apb(1'b1, hft_pkg::OFS_IRQ_MASK, 32'h0);
    @(posedge pclk);
    chk("irq_masked", 32'h0, 32'(irq));
    apb(1'b1, hft_pkg::OFS_IRQ_STAT, 32'h3);
    rd_chk("irq_cleared", hft_pkg::OFS_IRQ_STAT, 32'h0);
    // Gain limits and scaling of the chamber sum.
    apb(1'b1, hft_pkg::OFS_GAIN, 32'h600);
    apb(1'b1, hft_pkg::OFS_GAIN, 32'h601);
    rd_chk("gain_max", hft_pkg::OFS_GAIN, 32'h600);
    drive(64'h1770_1770_1770_1770, 1'b0);
    rd_chk("sel_gain_hi", hft_pkg::OFS_SEL_FLUX, 32'h2328);
    apb(1'b1, hft_pkg::OFS_GAIN, 32'h1FF);
    apb(1'b1, hft_pkg::OFS_GAIN, 32'h200);
    drive(64'h1770_1770_1770_1770, 1'b0);
    rd_chk("sel_gain_lo", hft_pkg::OFS_SEL_FLUX, 32'h0BB8);
    apb(1'b1, hft_pkg::OFS_GAIN, 32'h400);
    // A lower variable setpoint governs; the normal one still trips above it.
    apb(1'b1, hft_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, hft_pkg::OFS_VAR_SP, 32'h1388);
    apb(1'b1, hft_pkg::OFS_VAR_SP, 32'h30D5);
    rd_chk("var_sp_kept", hft_pkg::OFS_VAR_SP, 32'h1388);
    drive(64'h0000_0000_1388_1388, 1'b0);
    chk("var_trip", 32'hF, 32'(channel_trip));
    drive(64'h0, 1'b0);
    apb(1'b1, hft_pkg::OFS_VAR_SP, 32'h30D4);
    drive(64'h0000_0000_28EB_28EB, 1'b0);
    chk("normal_with_var", 32'hF, 32'(channel_trip));
    // Status: four trips, latched plant trip, no bypass, variable enabled.
    rd_chk("status", hft_pkg::OFS_STATUS, 32'h5F);
    // With no margin the trip clears one hundredth below the normal setpoint.
    apb(1'b1, hft_pkg::OFS_HYST, 32'h0);
    drive(64'h0000_0000_28EA_28EA, 1'b0);
    chk("hyst_zero", 32'h0, 32'(channel_trip));
    drive(64'h0000_0000_28EB_28EB, 1'b0);
    chk("normal_sp", 32'hF, 32'(channel_trip));
    // Unmapped place: error answer, zero data.
    apb(1'b1, 8'h20, 32'h5);
    chk("wr_unmapped", 32'h1, 32'(err));
    rd_chk("rd_unmapped", 8'h20, 32'h0);
    chk("rd_unmapped_err", 32'h1, 32'(err));
    // A second reset in mid-run clears the latch and restores every register.
    // Zero flux across the reset so no fresh event sets the sticky bits again.
    @(posedge pclk);
    presetn <= 1'b0;
    total_req <= '0;
    repeat (12) @(posedge pclk);
    chk("reset_plant", 32'h0, 32'({plant_trip, channel_trip}));
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd_chk("reset_value", rst_ofs[i], rst_val[i]);
    end
    tally_and_finish();
  end
endmodule : tb_top
